// *** hdl/slota_afe_cfg_regs.sv ***
// Slot A front-end configuration registers with their decode toward the analog front end.
`timescale 1ns/100ps
module slota_afe_cfg_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port from the serial control interface
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rdata_valid,
  // Timing core events
  input wire logic pulse_strobe,
  input wire logic slot_start,
  // Integration sequence controls
  output logic pulse_reverse,
  output logic [1:0] pulse_index,
  output logic window_open,
  // Analog front-end controls
  output logic [5:0] fe_mode,
  output logic integ_buffer_mode,
  output logic [8:0] int_res_kohm,
  output logic [3:0] buf_gain_x10,
  output logic [1:0] ch1_tia_code,
  output logic [1:0] ch2_tia_code,
  output logic [1:0] ch3_tia_code
);
  import slota_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0] order_q;
  logic [15:0] window_q;
  logic [15:0] fe_ctrl_q;
  logic [15:0] ch_gain_q;

  wire hit_order = (reg_addr == ORDER_ADDR);
  wire hit_window = (reg_addr == WINDOW_ADDR);
  wire hit_fe_ctrl = (reg_addr == FE_CTRL_ADDR);
  wire hit_ch_gain = (reg_addr == CH_GAIN_ADDR);

  // Only the slot A lanes are kept; the other bits of these words belong to other blocks.
  wire [15:0] order_wr_val = reg_wdata & ORDER_MASK;
  wire [15:0] ch_gain_wr_val = reg_wdata & CH_GAIN_MASK;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      order_q <= {12'h000, ORDER_RST};
      window_q <= WINDOW_RST;
      fe_ctrl_q <= FE_CTRL_RST;
      ch_gain_q <= CH_GAIN_RST;
    end else if (reg_wr) begin
      if (hit_order) begin
        order_q <= order_wr_val;
      end
      if (hit_window) begin
        window_q <= reg_wdata;
      end
      if (hit_fe_ctrl) begin
        fe_ctrl_q <= reg_wdata;
      end
      if (hit_ch_gain) begin
        ch_gain_q <= ch_gain_wr_val;
      end
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  // Unmapped offsets read as zero so a stray read never returns stale data.
  wire [15:0] rd_mux = hit_order ? order_q :
                       hit_window ? window_q :
                       hit_fe_ctrl ? fe_ctrl_q :
                       hit_ch_gain ? ch_gain_q : 16'h0000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : reg_rdata;
      reg_rdata_valid <= reg_rd;
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  wire [1:0] int_gain = fe_ctrl_q[INT_GAIN_LSB +: 2];
  wire as_buffer = fe_ctrl_q[BUF_BIT];
  wire ind_en = fe_ctrl_q[IND_EN_BIT];
  wire [1:0] shared_gain = fe_ctrl_q[SHARED_GAIN_LSB +: 2];
  wire [1:0] ch3_field = ch_gain_q[CH3_GAIN_LSB +: 2];
  wire [1:0] ch2_field = ch_gain_q[CH2_GAIN_LSB +: 2];

  slota_cfg_if cfg_bus ();
  assign cfg_bus.order = order_q[ORDER_LSB +: 4];
  assign cfg_bus.width = window_q[WIDTH_LSB +: 5];
  assign cfg_bus.start = window_q[START_LSB +: 11];

  // ****************************************
  // Gain decode
  // ****************************************
  // Channel 1 always follows the shared field: with per-channel gain on it is channel 1's own code.
  // Lane 0 carries channel 2 and lane 1 channel 3.
  wire [1:0] lane_sel [2];
  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    localparam int LANE_LSB = (lane == 0) ? CH2_GAIN_LSB : CH3_GAIN_LSB;
    wire [1:0] own_code = ch_gain_q[LANE_LSB +: 2];
    assign lane_sel[lane] = ind_en ? own_code : shared_gain;
  end
  wire [1:0] ch2_sel = lane_sel[0];
  wire [1:0] ch3_sel = lane_sel[1];

  // Code 3 is not defined for the integrator; it decodes to zero so the front end can flag it.
  wire [8:0] rint_sel = (int_gain == 2'h0) ? RINT_400K :
                        (int_gain == 2'h1) ? RINT_200K :
                        (int_gain == 2'h2) ? RINT_100K : 9'h000;
  wire [3:0] bgain_sel = (int_gain == 2'h2) ? BUF_GAIN_LOW :
                         (int_gain == 2'h3) ? 4'h0 : BUF_GAIN_UNITY;
  wire [8:0] rint_d = as_buffer ? 9'h000 : rint_sel;
  wire [3:0] bgain_d = as_buffer ? bgain_sel : 4'h0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fe_mode <= 6'h00;
      integ_buffer_mode <= 1'b0;
      int_res_kohm <= 9'h000;
      buf_gain_x10 <= 4'h0;
      ch1_tia_code <= 2'h0;
      ch2_tia_code <= 2'h0;
      ch3_tia_code <= 2'h0;
    end else begin
      fe_mode <= fe_ctrl_q[MODE_LSB +: 6];
      integ_buffer_mode <= as_buffer;
      int_res_kohm <= rint_d;
      buf_gain_x10 <= bgain_d;
      ch1_tia_code <= shared_gain;
      ch2_tia_code <= ch2_sel;
      ch3_tia_code <= ch3_sel;
    end
  end

  // ****************************************
  // Integration sequencer
  // ****************************************
  slota_integ_seq u_seq (
    .clk(clk),
    .sys_rst(sys_rst),
    .cfg(cfg_bus.seq),
    .pulse_strobe(pulse_strobe),
    .slot_start(slot_start),
    .pulse_reverse(pulse_reverse),
    .pulse_index(pulse_index),
    .window_open(window_open)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_fe_write;
    reg_wr && hit_fe_ctrl;
  endsequence

  sequence s_settle;
    ##2 1'b1;
  endsequence

  chk_ch3_individual: assert property (ind_en |=> ch3_tia_code == $past(ch3_field))
    else $error("channel 3 gain ignored its own field while enabled");
  chk_ch2_individual: assert property (ind_en |=> ch2_tia_code == $past(ch2_field))
    else $error("channel 2 gain ignored its own field while enabled");
  chk_shared_gain: assert property (!ind_en |=> ch2_tia_code == $past(shared_gain) &&
                                    ch3_tia_code == $past(shared_gain))
    else $error("shared gain not applied to all channels");
  chk_normal_rint: assert property (s_fe_write ##0 !reg_wdata[BUF_BIT] && reg_wdata[INT_GAIN_LSB +: 2] == 2'h1
                                    ##0 s_settle |-> int_res_kohm == RINT_200K && buf_gain_x10 == 4'h0)
    else $error("normal mode integrator resistor decode wrong");
  chk_buffer_gain: assert property (s_fe_write ##0 reg_wdata[BUF_BIT] && reg_wdata[INT_GAIN_LSB +: 2] == 2'h2
                                    ##0 s_settle |-> buf_gain_x10 == BUF_GAIN_LOW && int_res_kohm == 9'h000)
    else $error("buffer mode gain decode wrong");
  chk_normal_integrator: assert property (!as_buffer |=> !integ_buffer_mode && buf_gain_x10 == 4'h0)
    else $error("integrator left normal configuration while buffer select clear");
  chk_buffer_select: assert property ($rose(as_buffer) |=> integ_buffer_mode && int_res_kohm == 9'h000)
    else $error("integrator not turned into buffer");
  chk_order_write: assert property (reg_wr && hit_order |=> order_q[15:4] == 12'h000 &&
                                    cfg_bus.order == $past(reg_wdata[3:0]))
    else $error("order register write not taken");
  chk_window_write: assert property (reg_wr && hit_window |=> cfg_bus.width == $past(reg_wdata[15:11]) &&
                                     cfg_bus.start == $past(reg_wdata[10:0]))
    else $error("window register write not taken");
  chk_normal_400k: assert property (s_fe_write ##0 !reg_wdata[BUF_BIT] && reg_wdata[INT_GAIN_LSB +: 2] == 2'h0
                                    ##0 s_settle |-> int_res_kohm == RINT_400K && buf_gain_x10 == 4'h0)
    else $error("normal mode 400 kohm decode wrong");
  chk_normal_100k: assert property (s_fe_write ##0 !reg_wdata[BUF_BIT] && reg_wdata[INT_GAIN_LSB +: 2] == 2'h2
                                    ##0 s_settle |-> int_res_kohm == RINT_100K && buf_gain_x10 == 4'h0)
    else $error("normal mode 100 kohm decode wrong");
  chk_buffer_unity: assert property (s_fe_write ##0 reg_wdata[BUF_BIT] && reg_wdata[INT_GAIN_LSB +: 2] == 2'h1
                                     ##0 s_settle |-> buf_gain_x10 == BUF_GAIN_UNITY && int_res_kohm == 9'h000)
    else $error("buffer mode unity gain decode wrong");
  chk_gain_code3: assert property (s_fe_write ##0 reg_wdata[INT_GAIN_LSB +: 2] == 2'h3 ##0 s_settle |->
                                   int_res_kohm == 9'h000 && buf_gain_x10 == 4'h0)
    else $error("undefined integrator code not decoded to zero");
  chk_gain_hold: assert property (!(reg_wr && hit_fe_ctrl) ##1 !(reg_wr && hit_fe_ctrl) |=>
                                  $stable(int_res_kohm) && $stable(buf_gain_x10))
    else $error("integrator decode changed without a control write");
  chk_buffer_follow: assert property (as_buffer |=> integ_buffer_mode && int_res_kohm == 9'h000)
    else $error("integrator left buffer configuration while buffer select set");
  chk_ch1_shared: assert property (1'b1 |=> ch1_tia_code == $past(shared_gain))
    else $error("channel 1 gain does not follow the shared field");
  chk_ind_en_write: assert property (reg_wr && hit_fe_ctrl |=> ind_en == $past(reg_wdata[IND_EN_BIT]))
    else $error("per-channel gain enable write not taken");
  chk_ch_gain_write: assert property (reg_wr && hit_ch_gain |=> ch_gain_q[15:4] == 12'h000 &&
                                      ch2_field == $past(reg_wdata[1:0]) && ch3_field == $past(reg_wdata[3:2]))
    else $error("per-channel gain register write not taken");
  chk_order_read: assert property (reg_rd && hit_order |=> reg_rdata_valid &&
                                   reg_rdata == {12'h000, $past(order_q[3:0])})
    else $error("order register read back wrong");
  chk_window_read: assert property (reg_rd && hit_window |=> reg_rdata_valid && reg_rdata == $past(window_q))
    else $error("window register read back wrong");

endmodule

// *** hdl/slota_pkg.sv ***
// Constants, field layout and types for the slot A front-end configuration bank.
package slota_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ORDER_ADDR = 8'h17;
  localparam logic [7:0] WINDOW_ADDR = 8'h39;
  localparam logic [7:0] FE_CTRL_ADDR = 8'h42;
  localparam logic [7:0] CH_GAIN_ADDR = 8'h55;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ORDER_LSB = 0;
  localparam int WIDTH_LSB = 11;
  localparam int START_LSB = 0;
  localparam int MODE_LSB = 10;
  localparam int INT_GAIN_LSB = 8;
  localparam int BUF_BIT = 7;
  localparam int IND_EN_BIT = 6;
  localparam int SHARED_GAIN_LSB = 0;
  localparam int CH3_GAIN_LSB = 2;
  localparam int CH2_GAIN_LSB = 0;
  localparam logic [15:0] ORDER_MASK = 16'h000F;
  localparam logic [15:0] CH_GAIN_MASK = 16'h000F;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] ORDER_RST = 4'h0;
  localparam logic [4:0] WIDTH_RST = 5'h04;
  localparam logic [10:0] START_RST = 11'h2FC;
  localparam logic [5:0] MODE_RST = 6'h07;
  localparam logic [1:0] VREF_RST = 2'h3;
  localparam logic [1:0] RSVD_RST = 2'h2;
  localparam logic [15:0] WINDOW_RST = {WIDTH_RST, START_RST};
  localparam logic [15:0] FE_CTRL_RST = {MODE_RST, 2'h0, 1'b0, 1'b0, VREF_RST, RSVD_RST, 2'h0};
  localparam logic [15:0] CH_GAIN_RST = 16'h0000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 10000;
  localparam int WIDTH_STEP_PS = 1000000;
  localparam int START_STEP_PS = 31250;
  localparam int WIDTH_STEP_CYC = WIDTH_STEP_PS / CLK_PERIOD_PS;

  // ****************************************
  // Analog decode values
  // ****************************************
  localparam logic [8:0] RINT_400K = 9'h190;
  localparam logic [8:0] RINT_200K = 9'h0C8;
  localparam logic [8:0] RINT_100K = 9'h064;
  localparam logic [3:0] BUF_GAIN_UNITY = 4'hA;
  localparam logic [3:0] BUF_GAIN_LOW = 4'h7;

  typedef enum logic [1:0] {
    WIN_IDLE = 2'b00,
    WIN_DELAY = 2'b01,
    WIN_OPEN = 2'b11
  } slota_win_e;

endpackage

// *** hdl/slota_cfg_if.sv ***
// Carrier for the pulse order and window fields from the register bank to the sequencer.
`timescale 1ns/100ps
interface slota_cfg_if;
  logic [3:0] order;
  logic [4:0] width;
  logic [10:0] start;
  modport cfg (output order, output width, output start);
  modport seq (input order, input width, input start);
endinterface

// *** hdl/slota_integ_seq.sv ***
// Pulse polarity sequencer and integration window timer for slot A.
`timescale 1ns/100ps
module slota_integ_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration
  slota_cfg_if.seq cfg,
  // Timing core events
  input wire logic pulse_strobe,
  input wire logic slot_start,
  // Front-end controls
  output logic pulse_reverse,
  output logic [1:0] pulse_index,
  output logic window_open
);
  import slota_pkg::*;

  // ****************************************
  // Pulse polarity
  // ****************************************
  logic [1:0] pidx_q;
  logic pol_q;
  wire cur_bit = cfg.order[pidx_q];
  wire [31:0] width_prod = 32'(cfg.width) * WIDTH_STEP_CYC;
  wire [31:0] start_prod = (32'(cfg.start) * START_STEP_PS) / CLK_PERIOD_PS;
  wire [15:0] width_cyc = width_prod[15:0];
  wire [15:0] start_cyc = start_prod[15:0];

  // The index returns to zero at each slot start so that every slot begins with its first pulse.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pidx_q <= 2'h0;
      pol_q <= 1'b0;
    end else if (slot_start) begin
      pidx_q <= 2'h0;
    end else if (pulse_strobe) begin
      pidx_q <= pidx_q + 2'h1;
      pol_q <= cur_bit;
    end
  end

  assign pulse_reverse = pol_q;
  assign pulse_index = pidx_q;

  // ****************************************
  // Window timer
  // ****************************************
  slota_win_e state_q;
  logic [15:0] cnt_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= WIN_IDLE;
      cnt_q <= 16'h0000;
    end else if (slot_start) begin
      state_q <= WIN_DELAY;
      cnt_q <= start_cyc;
    end else begin
      case (state_q)
        WIN_DELAY: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (width_cyc == 16'h0000) begin
            state_q <= WIN_IDLE;
          end else begin
            state_q <= WIN_OPEN;
            cnt_q <= width_cyc - 16'h0001;
          end
        end
        WIN_OPEN: begin
          if (cnt_q == 16'h0000) begin
            state_q <= WIN_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= WIN_IDLE;
      endcase
    end
  end

  assign window_open = (state_q == WIN_OPEN);

  // ****************************************
  // Checks
  // ****************************************
  logic [15:0] since_q;
  logic [15:0] start_lat_q;
  logic [15:0] open_len_q;
  logic [15:0] width_lat_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      since_q <= 16'h0000;
      start_lat_q <= 16'h0000;
      open_len_q <= 16'h0000;
      width_lat_q <= 16'h0000;
    end else begin
      since_q <= slot_start ? 16'h0001 : since_q + 16'h0001;
      start_lat_q <= slot_start ? start_cyc : start_lat_q;
      open_len_q <= window_open ? open_len_q + 16'h0001 : 16'h0000;
      width_lat_q <= (state_q == WIN_DELAY && cnt_q == 16'h0000) ? width_cyc : width_lat_q;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_last_pulse;
    pulse_strobe && !slot_start && pidx_q == 2'h3;
  endsequence

  chk_pulse_wrap: assert property (s_last_pulse |=> pidx_q == 2'h0)
    else $error("pulse index did not wrap after the fourth pulse");
  chk_pulse_polarity: assert property (pulse_strobe && !slot_start |=> pulse_reverse == $past(cur_bit))
    else $error("pulse polarity does not follow its order bit");
  chk_window_start: assert property ($rose(window_open) |-> since_q == start_lat_q + 16'h0002)
    else $error("window opened at the wrong offset");
  chk_window_width: assert property ($fell(window_open) && !$past(slot_start) |-> open_len_q == width_lat_q)
    else $error("window stayed open for the wrong number of cycles");

endmodule

// *** verification/slota_afe_cfg_regs_tb_top.sv ***
// Self-checking testbench for the slot A front-end configuration register bank.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
  $display("wrong value at %0t ns: %s", $time, msg); end end

module slota_afe_cfg_regs_tb_top;
  import slota_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic reg_rdata_valid;
  logic pulse_strobe;
  logic slot_start;
  logic pulse_reverse;
  logic [1:0] pulse_index;
  logic window_open;
  logic [5:0] fe_mode;
  logic integ_buffer_mode;
  logic [8:0] int_res_kohm;
  logic [3:0] buf_gain_x10;
  logic [1:0] ch1_tia_code;
  logic [1:0] ch2_tia_code;
  logic [1:0] ch3_tia_code;
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 73031;
  logic [15:0] rd_q[$];
  logic [2:0] pr_q[$];
  logic strobed;
  logic [1:0] idx;
  logic [15:0] r;
  logic [15:0] g;
  int i;
  int j;
  int k;
  int h;
  int exp_k;
  int bound;
  logic [8:0] exp_rint;
  logic [3:0] exp_bgain;

  slota_afe_cfg_regs dut (
    .clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .pulse_strobe(pulse_strobe), .slot_start(slot_start),
    .pulse_reverse(pulse_reverse), .pulse_index(pulse_index), .window_open(window_open),
    .fe_mode(fe_mode), .integ_buffer_mode(integ_buffer_mode), .int_res_kohm(int_res_kohm),
    .buf_gain_x10(buf_gain_x10), .ch1_tia_code(ch1_tia_code), .ch2_tia_code(ch2_tia_code),
    .ch3_tia_code(ch3_tia_code)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ****************************************
  // Drivers
  // ****************************************
  // Tasks start just after an edge and return just after the next one, so calls chain back to back.
  task automatic acc(input logic w, input logic rd, input logic [7:0] a, input logic [15:0] d,
                     input logic [15:0] e);
    reg_wr = w;
    reg_rd = rd;
    reg_addr = a;
    reg_wdata = d;
    pulse_strobe = 1'b0;
    slot_start = 1'b0;
    if (rd) rd_q.push_back(e);
    @(posedge clk);
    #1;
  endtask

  task automatic pulse(input logic s, input logic p);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    slot_start = s;
    pulse_strobe = p;
    if (s) idx = 2'h0;
    else if (p) begin
      pr_q.push_back({idx + 2'h1, r[idx]});
      idx = idx + 2'h1;
    end
    @(posedge clk);
    #1;
  endtask

  task automatic print_verdict;
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Monitor
  // ****************************************
  always @(posedge clk) strobed <= pulse_strobe & ~slot_start & ~sys_rst;

  // Outputs are registered, so the falling edge sees them settled.
  always @(negedge clk) begin
    if (reg_rdata_valid === 1'b1) begin
      if (rd_q.size() == 0) `CHK(1'b1, 1'b0, "read data without request")
      else `CHK(reg_rdata, rd_q.pop_front(), "read data")
    end
    if (strobed === 1'b1) begin
      if (pr_q.size() == 0) `CHK(1'b1, 1'b0, "pulse result without strobe")
      else `CHK({pulse_index, pulse_reverse}, pr_q.pop_front(), "pulse polarity or index")
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pulse_strobe = 1'b0;
    slot_start = 1'b0;
    idx = 2'h0;
    r = 16'h0000;
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    acc(1'b0, 1'b1, ORDER_ADDR, 16'h0000, 16'h0000);
    acc(1'b0, 1'b1, WINDOW_ADDR, 16'h0000, 16'h22FC);
    acc(1'b0, 1'b1, FE_CTRL_ADDR, 16'h0000, 16'h1C38);
    acc(1'b0, 1'b1, CH_GAIN_ADDR, 16'h0000, 16'h0000);
    `CHK(int_res_kohm, 9'h190, "reset integrator resistor")
    `CHK(integ_buffer_mode, 1'b0, "reset buffer select")
    `CHK(fe_mode, 6'h07, "reset mode field")
    r = 16'($random(seed));
    acc(1'b1, 1'b1, 8'h20, r, 16'h0000);
    acc(1'b1, 1'b1, ORDER_ADDR, r, 16'h0000);
    // A read in the cycle of a write to the same register returns the old contents.
    acc(1'b1, 1'b1, CH_GAIN_ADDR, r, CH_GAIN_RST);
    acc(1'b1, 1'b1, WINDOW_ADDR, ~r, WINDOW_RST);
    acc(1'b0, 1'b1, WINDOW_ADDR, 16'h0000, ~r);
    acc(1'b0, 1'b1, ORDER_ADDR, 16'h0000, {12'h000, r[3:0]});
    acc(1'b0, 1'b1, CH_GAIN_ADDR, 16'h0000, {12'h000, r[3:0]});
    acc(1'b0, 1'b1, 8'h20, 16'h0000, 16'h0000);
    // Every integrator code in both modes, with and without per-channel gain.
    for (i = 0; i < 16; i++) begin
      r = 16'($random(seed));
      g = {6'h07, i[1:0], i[3], i[2], r[5:4], 2'h2, r[9:8]};
      acc(1'b1, 1'b0, CH_GAIN_ADDR, r, 16'h0000);
      acc(1'b1, 1'b0, FE_CTRL_ADDR, g, 16'h0000);
      acc(1'b0, 1'b1, FE_CTRL_ADDR, 16'h0000, g);
      pulse(1'b0, 1'b0);
      exp_rint = i[3] ? 9'h000 : i[1:0] == 0 ? 9'h190 : i[1:0] == 1 ? 9'h0C8 : i[1:0] == 2 ? 9'h064 : 9'h000;
      exp_bgain = !i[3] ? 4'h0 : i[1:0] < 2 ? 4'hA : i[1:0] == 2 ? 4'h7 : 4'h0;
      `CHK(int_res_kohm, exp_rint, "integrator resistor")
      `CHK(buf_gain_x10, exp_bgain, "buffer gain")
      `CHK(integ_buffer_mode, i[3], "buffer select")
      `CHK(fe_mode, 6'h07, "mode field")
      `CHK(ch1_tia_code, r[9:8], "channel 1 gain")
      `CHK(ch2_tia_code, i[2] ? r[1:0] : r[9:8], "channel 2 gain")
      `CHK(ch3_tia_code, i[2] ? r[3:2] : r[9:8], "channel 3 gain")
    end
    // Nine back-to-back strobes cross the four-pulse wrap twice.
    for (j = 0; j < 2; j++) begin
      r = 16'($random(seed));
      acc(1'b1, 1'b0, ORDER_ADDR, r, 16'h0000);
      pulse(1'b1, j[0]);
      `CHK(pulse_index, 2'h0, "index after slot start")
      for (k = 0; k < 9; k++) pulse(1'b0, 1'b1);
      pulse(1'b0, 1'b0);
    end
    // Window timing: reset values, a random short offset, and zero width.
    for (j = 0; j < 3; j++) begin
      r = 16'($random(seed));
      r = j == 0 ? 16'h22FC : j == 1 ? {5'h01, 5'h00, r[5:0]} : 16'h0005;
      acc(1'b1, 1'b0, WINDOW_ADDR, r, 16'h0000);
      pulse(1'b1, 1'b0);
      // The window opens on the edge after the offset count has run down to zero.
      exp_k = int'(r[10:0]) * START_STEP_PS / CLK_PERIOD_PS + 1;
      bound = exp_k + 200;
      k = 0;
      do begin
        pulse(1'b0, 1'b0);
        k++;
      end while (window_open !== 1'b1 && k < bound);
      `CHK(k, (r[15:11] == 0) ? bound : exp_k, "window start delay")
      if (k >= bound && r[15:11] != 5'h00) break;
      h = 0;
      while (window_open === 1'b1 && h < 3000) begin
        pulse(1'b0, 1'b0);
        h++;
      end
      `CHK(h, int'(r[15:11]) * 100, "window width")
      if (h >= 3000) break;
    end
    pulse(1'b0, 1'b0);
    pulse(1'b0, 1'b0);
    `CHK(rd_q.size() + pr_q.size(), 0, "results still outstanding")
    print_verdict();
  end
endmodule
